/* hw/wakeup_timer_measure_compare.sv */
// Wake-up timer and amplitude/phase measurement-compare block with Avalon-MM registers.
// Assumes an external front end that answers each start pulse with a done pulse and result.
// Contract
// R1: The range bit selects a 100 ms step when clear and a 10 ms step when set.
// R2: The wake-up period is the 3-bit timeout field plus one, times the step.
// R3: With the every-timeout bit set, each expiry raises an interrupt.
// R4: With the amplitude bit set, each expiry starts an amplitude measurement.
// R5: With the phase bit set, each expiry starts a phase measurement.
// R6: A timed amplitude result differing from its reference by more than the threshold interrupts.
// R7: A timed phase result differing from its reference by more than the threshold interrupts.
// R8: The amplitude include bit decides whether a tripping result enters the average.
// R9: The phase include bit decides whether a tripping result enters the average.
// R10: The two weight bits select an averaging weight of 4, 8, 16 or 32.
// R11: Amplitude bit 0 picks the stored reference when clear and the average when set.
// R12: Phase bit 0 picks the stored reference when clear and the average when set.
// R13: All registers here clear at reset and on the default-setting command; the command leaves the interrupt status and mask registers unchanged.
// R14: Index 34h reads the amplitude auto-average.
// R15: Index 35h reads the last amplitude result.
// R16: Index 33h holds the stored amplitude reference.
// R17: The average moves by the result-minus-average difference divided by the weight; the code divides result minus the selected reference.
//
// Decided for this implementation: the Avalon-MM register port.
module wakeup_timer_measure_compare
	import wakeup_pkg::*;
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Avalon-MM slave.
	input wire logic [9:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic [1:0] o_avs_response,
	// Measurement front end.
	output logic o_amp_start,
	input wire logic i_amp_done,
	input wire logic [7:0] i_amp_result,
	output logic o_phs_start,
	input wire logic i_phs_done,
	input wire logic [7:0] i_phs_result,
	// Interrupt.
	output logic o_irq
);
	meas_if amp_m ();
	meas_if phs_m ();

	logic [7:0] timer_ctrl_r;
	logic [7:0] amp_cfg_r;
	logic [7:0] amp_ref_r;
	logic [7:0] phs_cfg_r;
	logic [7:0] phs_ref_r;
	logic [7:0] irq_status_r;
	logic [7:0] irq_mask_r;
	logic ack_r;
	logic amp_pending_r;
	logic phs_pending_r;
	logic set_default;
	logic expire;
	logic timer_enable;
	logic access;
	logic [7:0] index;
	logic wr_lane0;
	logic do_write;
	logic do_read;
	logic mapped;
	logic [7:0] read_byte;
	logic [7:0] irq_set;

	typedef enum logic [1:0] {OKAY_type_unused, SLVERR_type_unused} unused_type;

	assign access = i_avs_read || i_avs_write;
	assign index = i_avs_address[9:2];
	assign wr_lane0 = i_avs_byteenable[0];
	// One wait cycle per access: the request is taken at the edge where ack_r is high.
	assign o_avs_waitrequest = access && !ack_r;
	assign do_write = i_avs_write && ack_r && wr_lane0;
	assign do_read = i_avs_read && ack_r;
	assign set_default = do_write && index == IDX_COMMAND && i_avs_writedata[7:0] == CMD_SET_DEFAULT;

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= access && !ack_r;
		end
	end

	always_comb begin
		mapped = 1'b1;
		case (index)
			IDX_TIMER_CTRL: read_byte = timer_ctrl_r;
			IDX_AMP_CFG: read_byte = amp_cfg_r;
			IDX_AMP_REF: read_byte = amp_ref_r; // see R16
			IDX_AMP_AVG: read_byte = amp_m.average; // see R14
			IDX_AMP_RES: read_byte = amp_m.last; // see R15
			IDX_PHS_CFG: read_byte = phs_cfg_r;
			IDX_PHS_REF: read_byte = phs_ref_r;
			IDX_PHS_AVG: read_byte = phs_m.average;
			IDX_PHS_RES: read_byte = phs_m.last;
			IDX_IRQ_STATUS: read_byte = irq_status_r;
			IDX_IRQ_MASK: read_byte = irq_mask_r;
			IDX_COMMAND: read_byte = REG_RESET;
			default: begin
				read_byte = REG_RESET;
				mapped = 1'b0;
			end
		endcase
	end

	// Read data and response are captured in the wait cycle and stand in the acknowledging cycle.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_avs_readdata <= 32'h0000_0000;
			o_avs_response <= 2'b00;
		end else if (access && !ack_r) begin
			o_avs_readdata <= {24'h00_0000, read_byte};
			o_avs_response <= mapped ? 2'b00 : 2'b10;
		end else begin
			o_avs_readdata <= 32'h0000_0000;
			o_avs_response <= 2'b00;
		end
	end

	// Configuration registers; the default command clears them like reset does.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			timer_ctrl_r <= REG_RESET;
			amp_cfg_r <= REG_RESET;
			amp_ref_r <= REG_RESET;
			phs_cfg_r <= REG_RESET;
			phs_ref_r <= REG_RESET;
		end else if (set_default) begin
			timer_ctrl_r <= REG_RESET; // see R13
			amp_cfg_r <= REG_RESET;
			amp_ref_r <= REG_RESET;
			phs_cfg_r <= REG_RESET;
			phs_ref_r <= REG_RESET;
		end else if (do_write) begin
			case (index)
				IDX_TIMER_CTRL: timer_ctrl_r <= {i_avs_writedata[7:1], 1'b0};
				IDX_AMP_CFG: amp_cfg_r <= i_avs_writedata[7:0];
				IDX_AMP_REF: amp_ref_r <= i_avs_writedata[7:0];
				IDX_PHS_CFG: phs_cfg_r <= i_avs_writedata[7:0];
				IDX_PHS_REF: phs_ref_r <= i_avs_writedata[7:0];
				default: begin
				end
			endcase
		end
	end

	// The timer runs only while some action on expiry is enabled.
	assign timer_enable = timer_ctrl_r[TC_IRQ_EVERY_BIT] || timer_ctrl_r[TC_AMP_BIT]
		|| timer_ctrl_r[TC_PHS_BIT];

	wakeup_period_timer u_timer (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_enable(timer_enable),
		.i_range_short(timer_ctrl_r[TC_RANGE_BIT]), // see R1
		.i_timeout(timer_ctrl_r[TC_TIMEOUT_LSB +: 3]), // see R2
		.o_expire(expire)
	);

	assign o_amp_start = expire && timer_ctrl_r[TC_AMP_BIT]; // see R4
	assign o_phs_start = expire && timer_ctrl_r[TC_PHS_BIT]; // see R5

	// Only results requested by the timer are compared; stray done pulses are ignored.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			amp_pending_r <= 1'b0;
			phs_pending_r <= 1'b0;
		end else begin
			amp_pending_r <= o_amp_start || (amp_pending_r && !i_amp_done && !set_default);
			phs_pending_r <= o_phs_start || (phs_pending_r && !i_phs_done && !set_default);
		end
	end

	assign amp_m.start = o_amp_start;
	assign amp_m.done = i_amp_done && amp_pending_r;
	assign amp_m.result = i_amp_result;
	assign amp_m.cfg = amp_cfg_r;
	assign amp_m.stored_ref = amp_ref_r;
	assign amp_m.clear = set_default;
	assign phs_m.start = o_phs_start;
	assign phs_m.done = i_phs_done && phs_pending_r;
	assign phs_m.result = i_phs_result;
	assign phs_m.cfg = phs_cfg_r;
	assign phs_m.stored_ref = phs_ref_r;
	assign phs_m.clear = set_default;

	measure_compare u_amp (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.m(amp_m.chan)
	);

	measure_compare u_phs (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.m(phs_m.chan)
	);

	always_comb begin
		irq_set = 8'h00;
		irq_set[IRQ_TIMEOUT_BIT] = expire && timer_ctrl_r[TC_IRQ_EVERY_BIT]; // see R3
		irq_set[IRQ_AMP_BIT] = amp_m.trip; // see R6
		irq_set[IRQ_PHS_BIT] = phs_m.trip; // see R7
	end

	// A read clears only the bits it returned, so an event after the capture is not lost.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			irq_status_r <= REG_RESET;
		end else if (do_read && index == IDX_IRQ_STATUS) begin
			irq_status_r <= (irq_status_r & ~o_avs_readdata[7:0]) | irq_set;
		end else begin
			irq_status_r <= irq_status_r | irq_set;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			irq_mask_r <= REG_RESET;
		end else if (do_write && index == IDX_IRQ_MASK) begin
			irq_mask_r <= i_avs_writedata[7:0];
		end
	end

	assign o_irq = |(irq_status_r & irq_mask_r);
endmodule : wakeup_timer_measure_compare

/* inc/wakeup_pkg.sv */
// Constants for the wake-up timer and measurement-compare block.
// Assumes a 25 MHz core clock and an Avalon-MM register slave with 32-bit data.
package wakeup_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int STEP_LONG_MS = 100;
	localparam int STEP_SHORT_MS = 10;
	localparam int STEP_LONG_CYCLES = CLK_HZ / 1000 * STEP_LONG_MS;
	localparam int STEP_SHORT_CYCLES = CLK_HZ / 1000 * STEP_SHORT_MS;
	// Register indices; byte address is four times the index.
	localparam logic [7:0] IDX_TIMER_CTRL = 8'h31;
	localparam logic [7:0] IDX_AMP_CFG = 8'h32;
	localparam logic [7:0] IDX_AMP_REF = 8'h33;
	localparam logic [7:0] IDX_AMP_AVG = 8'h34;
	localparam logic [7:0] IDX_AMP_RES = 8'h35;
	localparam logic [7:0] IDX_PHS_CFG = 8'h36;
	localparam logic [7:0] IDX_PHS_REF = 8'h37;
	localparam logic [7:0] IDX_PHS_AVG = 8'h38;
	localparam logic [7:0] IDX_PHS_RES = 8'h39;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
	localparam logic [7:0] IDX_COMMAND = 8'h42;
	localparam logic [7:0] CMD_SET_DEFAULT = 8'hC1;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Timer control fields.
	localparam int TC_RANGE_BIT = 7;
	localparam int TC_TIMEOUT_LSB = 4;
	localparam int TC_IRQ_EVERY_BIT = 3;
	localparam int TC_AMP_BIT = 2;
	localparam int TC_PHS_BIT = 1;
	// Measurement configuration fields.
	localparam int CFG_THRESH_LSB = 4;
	localparam int CFG_INCLUDE_BIT = 3;
	localparam int CFG_WEIGHT_LSB = 1;
	localparam int CFG_REF_SRC_BIT = 0;
	// Interrupt status bits.
	localparam int IRQ_TIMEOUT_BIT = 0;
	localparam int IRQ_AMP_BIT = 1;
	localparam int IRQ_PHS_BIT = 2;
	localparam int WEIGHT_SHIFT_BASE = 2;
endpackage : wakeup_pkg

/* inc/meas_if.sv */
// Carries one measurement channel's request, result and compare outcome.
// Assumes a single core clock domain on both ends.
interface meas_if;
	logic start;
	logic done;
	logic [7:0] result;
	logic [7:0] cfg;
	logic [7:0] stored_ref;
	logic clear;
	logic trip;
	logic [7:0] average;
	logic [7:0] last;
	modport ctrl (output start, done, result, cfg, stored_ref, clear, input trip, average, last);
	modport chan (input start, done, result, cfg, stored_ref, clear, output trip, average, last);
endinterface : meas_if

/* hw/wakeup_period_timer.sv */
// Wake-up period counter producing a one-cycle expiry pulse.
// Assumes the range and timeout fields come from the timer control register.
module wakeup_period_timer
	import wakeup_pkg::*;
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Control.
	input wire logic i_enable,
	input wire logic i_range_short,
	input wire logic [2:0] i_timeout,
	// Expiry.
	output logic o_expire
);
	logic [24:0] step_r;
	logic [2:0] steps_r;
	logic [24:0] step_last;

	// Both step lengths fit 25 bits at this clock.
	assign step_last = i_range_short ? 25'(STEP_SHORT_CYCLES - 1) : 25'(STEP_LONG_CYCLES - 1); // see R1

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			step_r <= '0;
			steps_r <= '0;
			o_expire <= 1'b0;
		end else if (!i_enable) begin
			step_r <= '0;
			steps_r <= '0;
			o_expire <= 1'b0;
		end else if (step_r >= step_last) begin
			step_r <= '0;
			if (steps_r >= i_timeout) begin // see R2
				steps_r <= '0;
				o_expire <= 1'b1;
			end else begin
				steps_r <= steps_r + 3'h1;
				o_expire <= 1'b0;
			end
		end else begin
			step_r <= step_r + 25'h1;
			o_expire <= 1'b0;
		end
	end
endmodule : wakeup_period_timer

/* hw/measure_compare.sv */
// One compare channel: last result, auto-average and threshold compare.
// Assumes results arrive as one-cycle done pulses from the measurement front end.
module measure_compare
	import wakeup_pkg::*;
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Channel.
	meas_if.chan m
);
	logic [7:0] ref_val;
	logic [8:0] diff;
	logic [7:0] mag;
	logic trip_now;
	logic [1:0] weight;
	logic [9:0] avg_delta;
	logic [9:0] avg_next;

	assign ref_val = m.cfg[CFG_REF_SRC_BIT] ? m.average : m.stored_ref; // see R11 R12
	assign diff = {1'b0, m.result} - {1'b0, ref_val};
	assign mag = diff[8] ? 8'(-diff) : diff[7:0];
	assign trip_now = mag > {4'h0, m.cfg[7:CFG_THRESH_LSB]}; // see R6 R7
	assign weight = m.cfg[CFG_WEIGHT_LSB +: 2];
	// Signed step of result minus the selected reference, divided by 4, 8, 16 or 32.
	assign avg_delta = 10'($signed({diff[8], diff}) >>> (WEIGHT_SHIFT_BASE + int'(weight))); // see R10 R17
	assign avg_next = {2'b00, m.average} + avg_delta;

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			m.last <= REG_RESET;
		end else if (m.clear) begin
			m.last <= REG_RESET; // see R13
		end else if (m.done) begin
			m.last <= m.result;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			m.average <= REG_RESET;
		end else if (m.clear) begin
			m.average <= REG_RESET;
		end else if (m.done && (!trip_now || m.cfg[CFG_INCLUDE_BIT])) begin // see R8 R9
			m.average <= avg_next[7:0];
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			m.trip <= 1'b0;
		end else begin
			m.trip <= m.done && !m.clear && trip_now;
		end
	end
endmodule : measure_compare

/* verification/wakeup_asserts.sv */
// Checker for the wake-up block's register readback and start outputs.
// Assumes it is bound to the top module and sees only its ports.
module wakeup_asserts
	import wakeup_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [9:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic o_amp_start,
	input wire logic o_phs_start
);
	logic [7:0] ctl_r, acfg_r, aref_r, pcfg_r;
	logic [7:0] idx;
	logic wr_ok;
	logic rd_ok;
	assign idx = i_avs_address[9:2];
	assign wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
	assign rd_ok = i_avs_read && !o_avs_waitrequest;
	// Shadows follow accepted writes so reads of the four shadowed registers are judged against the last write.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset || (wr_ok && idx == IDX_COMMAND && i_avs_writedata[7:0] == CMD_SET_DEFAULT)) begin
			ctl_r <= 8'h00;
			acfg_r <= 8'h00;
			aref_r <= 8'h00;
			pcfg_r <= 8'h00;
		end else if (wr_ok) begin
			if (idx == IDX_TIMER_CTRL) ctl_r <= {i_avs_writedata[7:1], 1'b0};
			if (idx == IDX_AMP_CFG) acfg_r <= i_avs_writedata[7:0];
			if (idx == IDX_AMP_REF) aref_r <= i_avs_writedata[7:0];
			if (idx == IDX_PHS_CFG) pcfg_r <= i_avs_writedata[7:0];
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	ctl_read_a: assert property (rd_ok && idx == IDX_TIMER_CTRL |-> o_avs_readdata == {24'h000000, ctl_r})
		else $error("timer control readback differs");
	amp_cfg_read_a: assert property (rd_ok && idx == IDX_AMP_CFG |-> o_avs_readdata[7:0] == acfg_r)
		else $error("amplitude config readback differs");
	amp_ref_read_a: assert property (rd_ok && idx == IDX_AMP_REF |-> o_avs_readdata[7:0] == aref_r)
		else $error("amplitude reference readback differs");
	phs_cfg_read_a: assert property (rd_ok && idx == IDX_PHS_CFG |-> o_avs_readdata[7:0] == pcfg_r)
		else $error("phase config readback differs");
	read_upper_a: assert property (rd_ok |-> o_avs_readdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	amp_start_en_a: assert property (o_amp_start |-> ctl_r[TC_AMP_BIT])
		else $error("amplitude start while disabled");
	phs_start_en_a: assert property (o_phs_start |-> ctl_r[TC_PHS_BIT])
		else $error("phase start while disabled");
	start_pair_a: assert property (o_amp_start && ctl_r[TC_PHS_BIT] |-> o_phs_start)
		else $error("phase start missing at expiry");
	amp_pulse_a: assert property ($rose(o_amp_start) |=> $fell(o_amp_start))
		else $error("amplitude start longer than one cycle");
endmodule : wakeup_asserts

bind wakeup_timer_measure_compare wakeup_asserts chk (.i_core_clk, .i_reset, .i_avs_address,
	.i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
	.o_avs_waitrequest, .o_amp_start, .o_phs_start);

/* verification/tb_top.sv */
// Self-checking bench for the wake-up block's register side.
// Models a front end that sends one unrequested done pulse on each channel; a timer expiry lies far beyond this run's length.
module tb_top
	import wakeup_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_core_clk, i_reset, i_avs_read, i_avs_write, i_amp_done, i_phs_done;
	logic [9:0] i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata;
	logic [3:0] i_avs_byteenable;
	logic [7:0] i_amp_result, i_phs_result;
	logic o_avs_waitrequest, o_amp_start, o_phs_start, o_irq;
	logic [1:0] o_avs_response;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;
	wakeup_timer_measure_compare dut (.i_core_clk, .i_reset, .i_avs_address, .i_avs_read,
		.i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
		.o_avs_response, .o_amp_start, .i_amp_done, .i_amp_result, .o_phs_start, .i_phs_done,
		.i_phs_result, .o_irq);
	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end
	task automatic close_out();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	// A runaway wait is cut short here; normal runs need fewer than 200 cycles.
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t data got %h exp %h", $time, got, exp);
		end
	endtask : cmp_data
	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t resp got %h exp %h", $time, got, exp);
		end
	endtask : cmp_resp
	// Data and response are captured at the negedge before the accepting edge.
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rsp);
		@(posedge i_core_clk);
		i_avs_address <= {idx, 2'b00};
		i_avs_writedata <= {24'h000000, wd};
		i_avs_byteenable <= be;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		@(negedge i_core_clk);
		while (o_avs_waitrequest)
			@(negedge i_core_clk);
		rd = o_avs_readdata;
		rsp = o_avs_response;
		@(posedge i_core_clk);
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [31:0] d;
		logic [1:0] r;
		bus(1'b1, idx, wd, 4'hF, d, r);
	endtask : wr
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		bus(1'b0, idx, 8'h00, 4'hF, d, r);
		cmp_data(d, {24'h000000, exp});
		cmp_resp(r, er);
	endtask : rd_chk
	task automatic t_reset_values();
		for (int i = 0; i < 9; i++)
			rd_chk(IDX_TIMER_CTRL + 8'(i), 8'h00, 2'b00);
		rd_chk(IDX_IRQ_STATUS, 8'h00, 2'b00);
		rd_chk(IDX_IRQ_MASK, 8'h00, 2'b00);
		$display("reset values done");
	endtask : t_reset_values
	task automatic t_read_write();
		wr(IDX_TIMER_CTRL, 8'hF5);
		rd_chk(IDX_TIMER_CTRL, 8'hF4, 2'b00);
		for (int c = 0; c < 4; c++) begin
			wr(IDX_AMP_CFG, {4'hA, c[0], c[1:0], c[1]});
			rd_chk(IDX_AMP_CFG, {4'hA, c[0], c[1:0], c[1]}, 2'b00);
		end
		wr(IDX_AMP_REF, 8'h5A);
		rd_chk(IDX_AMP_REF, 8'h5A, 2'b00);
		wr(IDX_PHS_CFG, 8'hCB);
		rd_chk(IDX_PHS_CFG, 8'hCB, 2'b00);
		$display("read write done");
	endtask : t_read_write
	task automatic t_read_only();
		logic [31:0] d;
		logic [1:0] r;
		wr(IDX_AMP_AVG, 8'hFF);
		wr(IDX_AMP_RES, 8'hFF);
		bus(1'b1, IDX_AMP_REF, 8'h11, 4'h0, d, r);
		@(posedge i_core_clk);
		i_amp_done <= 1'b1;
		i_phs_done <= 1'b1;
		@(posedge i_core_clk);
		i_amp_done <= 1'b0;
		i_phs_done <= 1'b0;
		rd_chk(IDX_AMP_AVG, 8'h00, 2'b00);
		rd_chk(IDX_AMP_RES, 8'h00, 2'b00);
		rd_chk(IDX_AMP_REF, 8'h5A, 2'b00);
		rd_chk(8'h50, 8'h00, 2'b10);
		wr(8'h50, 8'h33);
		$display("read only done");
	endtask : t_read_only
	task automatic t_default();
		wr(IDX_IRQ_MASK, 8'hFF);
		@(negedge i_core_clk);
		cmp_data({31'h0, o_irq}, 32'h0);
		wr(IDX_COMMAND, CMD_SET_DEFAULT);
		rd_chk(IDX_TIMER_CTRL, 8'h00, 2'b00);
		rd_chk(IDX_AMP_CFG, 8'h00, 2'b00);
		rd_chk(IDX_AMP_REF, 8'h00, 2'b00);
		rd_chk(IDX_PHS_CFG, 8'h00, 2'b00);
		rd_chk(IDX_IRQ_MASK, 8'hFF, 2'b00);
		wr(IDX_TIMER_CTRL, 8'h8E);
		@(posedge i_core_clk);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_reset <= 1'b0;
		rd_chk(IDX_TIMER_CTRL, 8'h00, 2'b00);
		$display("default and reset done");
	endtask : t_default
	initial begin
		i_reset = 1'b1;
		{i_avs_read, i_avs_write, i_amp_done, i_phs_done} = 4'h0;
		i_avs_address = 10'h000;
		i_avs_writedata = 32'h00000000;
		i_avs_byteenable = 4'h0;
		i_amp_result = 8'h77;
		i_phs_result = 8'h66;
		repeat (5) @(posedge i_core_clk);
		i_reset <= 1'b0;
		t_reset_values();
		t_read_write();
		t_read_only();
		t_default();
		close_out();
	end
endmodule : tb_top
